// [include/aac_pkg.sv]
// Constants, field layout and carrier types for the auxiliary converter control.
// Assumes one 100 MHz clock domain; shared by the control top and the averager.
package aac_pkg;

  // ********************************************************************
  // Register map
  // ********************************************************************
  localparam logic [7:0] AAC_ADDR_FIRST_HI = 8'h1a;
  localparam logic [7:0] AAC_ADDR_FIRST_LO = 8'h1b;
  localparam logic [7:0] AAC_ADDR_SECOND_HI = 8'h1c;
  localparam logic [7:0] AAC_ADDR_SECOND_LO = 8'h1d;
  localparam logic [7:0] AAC_ADDR_CTRL = 8'h22;
  localparam logic [7:0] AAC_CTRL_RESET = 8'h00;
  localparam logic [7:0] AAC_READ_ZERO = 8'h00;

  // ********************************************************************
  // Result layout and averaging
  // ********************************************************************
  localparam int AAC_RESULT_W = 10;
  localparam int AAC_HI_LSB = 2;
  localparam int AAC_LO_W = 2;
  localparam int AAC_COUNT_W = 3;
  localparam int AAC_ACC_W = 16;
  localparam int AAC_REMAIN_W = 7;
  localparam logic [2:0] AAC_CODE_RESERVED = 3'h7;
  localparam logic [9:0] AAC_RESULT_RESET = 10'h000;

  // Control register fields, msb first
  typedef struct packed {
    logic side_port_enable;
    logic side_port_owner_select;
    logic ref_internal_second;
    logic spare;
    logic start_second;
    logic ref_internal_first;
    logic first_conv_input_one;
    logic start_first;
  } aac_ctrl_t;

  // Sample return from one converter: done pulse and data
  typedef struct packed {
    logic done;
    logic [AAC_RESULT_W-1:0] data;
  } aac_sample_t;

  typedef enum logic [0:0] {
    AAC_IDLE = 1'b0,
    AAC_WAIT = 1'b1
  } aac_state_t;

endpackage

// [rtl/aac_average.sv]
// Averaging sequencer for one housekeeping converter.
// Assumes the converter answers each sample_start with one done pulse on the same clock.
module aac_average import aac_pkg::*; #(
  parameter int RESULT_W = AAC_RESULT_W
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic ce,
  input wire logic start,
  input wire logic [AAC_COUNT_W-1:0] count_code,
  input wire aac_sample_t sample_in,
  output logic sample_start,
  output logic busy,
  output logic result_valid,
  output logic [RESULT_W-1:0] result
);

  // ********************************************************************
  // Sequencer state
  // ********************************************************************
  aac_state_t state, next_state;
  logic [AAC_ACC_W-1:0] acc, next_acc;
  logic [AAC_REMAIN_W-1:0] remain, next_remain;
  logic [AAC_COUNT_W-1:0] shift, next_shift;
  logic next_sample_start, next_result_valid;
  logic [RESULT_W-1:0] next_result;
  logic [AAC_ACC_W-1:0] sum;

  // Next values; reserved code is refused so no start reaches the converter
  always_comb begin
    next_state = state;
    next_acc = acc;
    next_remain = remain;
    next_shift = shift;
    next_sample_start = 1'b0;
    next_result_valid = 1'b0;
    next_result = result;
    sum = acc + AAC_ACC_W'(sample_in.data);
    case (state)
      AAC_IDLE: begin
        if (start && count_code != AAC_CODE_RESERVED) begin
          next_acc = '0;
          next_remain = AAC_REMAIN_W'((1 << count_code) - 1);
          next_shift = count_code;
          next_sample_start = 1'b1;
          next_state = AAC_WAIT;
        end
      end
      AAC_WAIT: begin
        if (sample_in.done) begin
          next_acc = sum;
          if (remain == '0) begin
            // Power-of-two count, so the mean is a plain shift
            next_result = RESULT_W'(sum >> shift);
            next_result_valid = 1'b1;
            next_state = AAC_IDLE;
          end else begin
            next_remain = remain - 1'b1;
            next_sample_start = 1'b1;
          end
        end
      end
      default: next_state = AAC_IDLE;
    endcase
  end

  // Registers, frozen while ce is low
  always_ff @(posedge clk) begin
    if (reset) begin
      state <= AAC_IDLE;
      acc <= '0;
      remain <= '0;
      shift <= '0;
      sample_start <= 1'b0;
      result_valid <= 1'b0;
      result <= '0;
    end else if (ce) begin
      state <= next_state;
      acc <= next_acc;
      remain <= next_remain;
      shift <= next_shift;
      sample_start <= next_sample_start;
      result_valid <= next_result_valid;
      result <= next_result;
    end
  end

  assign busy = (state != AAC_IDLE);

  // ********************************************************************
  // Checks
  // ********************************************************************
  property p_reserved_refused;
    @(posedge clk) disable iff (reset)
      (ce && state == AAC_IDLE && start && count_code == AAC_CODE_RESERVED)
      |=> state == AAC_IDLE && !sample_start;
  endproperty
  a_reserved_refused: assert property (p_reserved_refused)
    else $error("reserved count code started a conversion");

  property p_launch;
    @(posedge clk) disable iff (reset)
      (ce && state == AAC_IDLE && start && count_code != AAC_CODE_RESERVED)
      |=> sample_start && state == AAC_WAIT;
  endproperty
  a_launch: assert property (p_launch)
    else $error("start did not launch a sample");

  property p_single_sample;
    @(posedge clk) disable iff (reset)
      (ce && state == AAC_WAIT && shift == '0 && sample_in.done)
      |=> result_valid && result == $past(sample_in.data);
  endproperty
  a_single_sample: assert property (p_single_sample)
    else $error("one-sample average differs from the sample");

endmodule

// [rtl/aac_control.sv]
// Control of two housekeeping converters: register port, side port and result storage.
// Assumes register port and converters share clk; side-port start pin is asynchronous.

// Summary of operation
// - Result registers hold last conversion per converter; writes leave them unchanged.
// - First converter has a two-input mux chosen by a control bit.
// - Each 10-bit result reads as upper eight bits plus low bits.
// - Bit 7 lets the side port start and read one converter.
// - Bit 6 low gives side port to first converter, high to second.
// - Bits 5 and 2 high pick internal reference, default external.
// - Bit 1 low samples input two, high samples input one.
// - Start bits 3 and 0 launch conversions and always read zero.
// - Sample-count code selects 1 to 64 averaged samples; code 7 unused.
module aac_control import aac_pkg::*; #(
  parameter int RESULT_W = AAC_RESULT_W
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic ce,
  input wire logic [7:0] reg_addr,
  input wire logic reg_write,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_read,
  output logic [7:0] reg_rdata,
  input wire logic [AAC_COUNT_W-1:0] avg_count_code,
  input wire logic side_start_pin,
  output logic side_done,
  output logic [RESULT_W-1:0] side_result,
  output logic first_start,
  output logic second_start,
  input wire aac_sample_t first_sample,
  input wire aac_sample_t second_sample,
  output logic first_conv_input_one,
  output logic first_ref_internal,
  output logic second_ref_internal
);

  // ********************************************************************
  // State
  // ********************************************************************
  aac_ctrl_t ctrl, next_ctrl;
  logic [RESULT_W-1:0] res_first, next_res_first;
  logic [RESULT_W-1:0] res_second, next_res_second;
  logic [7:0] next_rdata;
  logic next_side_done;
  logic [RESULT_W-1:0] next_side_result;
  logic [1:0] side_sync;
  logic side_prev;
  logic side_edge;
  logic ctrl_write;
  aac_ctrl_t wr_fields;
  logic go_first, go_second;
  logic [1:0] avg_start, avg_busy, avg_valid, avg_launch;
  logic [RESULT_W-1:0] avg_result [2];
  aac_sample_t samples [2];

  // Read decode: results split into upper eight and low bits
  function automatic logic [7:0] read_mux(input logic [7:0] addr, input aac_ctrl_t c,
                                          input logic [RESULT_W-1:0] ra,
                                          input logic [RESULT_W-1:0] rb);
    logic [7:0] v;
    v = AAC_READ_ZERO;
    if (addr == AAC_ADDR_FIRST_HI) begin
      v = ra[RESULT_W-1:AAC_HI_LSB];
    end else if (addr == AAC_ADDR_FIRST_LO) begin
      v = 8'(ra[AAC_LO_W-1:0]);
    end else if (addr == AAC_ADDR_SECOND_HI) begin
      v = rb[RESULT_W-1:AAC_HI_LSB];
    end else if (addr == AAC_ADDR_SECOND_LO) begin
      v = 8'(rb[AAC_LO_W-1:0]);
    end else if (addr == AAC_ADDR_CTRL) begin
      v = c;
    end
    return v;
  endfunction

  // ********************************************************************
  // Start requests
  // ********************************************************************
  // Side pin edge only after two flops; a held pin starts one conversion
  assign side_edge = side_sync[1] & ~side_prev;
  assign ctrl_write = reg_write && reg_addr == AAC_ADDR_CTRL;
  // Field view of the write data, so start bits are picked by name
  assign wr_fields = aac_ctrl_t'(reg_wdata);
  assign go_first = (ctrl_write && wr_fields.start_first)
    || (side_edge && ctrl.side_port_enable && !ctrl.side_port_owner_select);
  assign go_second = (ctrl_write && wr_fields.start_second)
    || (side_edge && ctrl.side_port_enable && ctrl.side_port_owner_select);
  // A start while busy is dropped rather than queued
  assign avg_start = {go_second & ~avg_busy[1], go_first & ~avg_busy[0]};
  assign samples[0] = first_sample;
  assign samples[1] = second_sample;

  // One averager per converter
  generate
    for (genvar i = 0; i < 2; i++) begin : g_avg
      aac_average #(.RESULT_W(RESULT_W)) u_avg (
        .clk(clk),
        .reset(reset),
        .ce(ce),
        .start(avg_start[i]),
        .count_code(avg_count_code),
        .sample_in(samples[i]),
        .sample_start(avg_launch[i]),
        .busy(avg_busy[i]),
        .result_valid(avg_valid[i]),
        .result(avg_result[i])
      );
    end
  endgenerate

  // ********************************************************************
  // Next values
  // ********************************************************************
  always_comb begin
    next_ctrl = ctrl;
    if (ctrl_write) begin
      next_ctrl = reg_wdata;
      next_ctrl.start_first = 1'b0;
      next_ctrl.start_second = 1'b0;
    end
    // Whole 10-bit word stored at once, halves never mixed
    next_res_first = avg_valid[0] ? avg_result[0] : res_first;
    next_res_second = avg_valid[1] ? avg_result[1] : res_second;
    next_rdata = reg_read ? read_mux(reg_addr, ctrl, res_first, res_second) : reg_rdata;
    // Side port sees only the converter it owns
    next_side_done = ctrl.side_port_enable
      && (ctrl.side_port_owner_select ? avg_valid[1] : avg_valid[0]);
    next_side_result = side_result;
    if (next_side_done) begin
      next_side_result = ctrl.side_port_owner_select ? avg_result[1] : avg_result[0];
    end
  end

  // Registers, all frozen while ce is low
  always_ff @(posedge clk) begin
    if (reset) begin
      ctrl <= AAC_CTRL_RESET;
      res_first <= AAC_RESULT_RESET;
      res_second <= AAC_RESULT_RESET;
      reg_rdata <= AAC_READ_ZERO;
      side_done <= 1'b0;
      side_result <= AAC_RESULT_RESET;
      side_sync <= 2'h0;
      side_prev <= 1'b0;
      first_start <= 1'b0;
      second_start <= 1'b0;
      first_conv_input_one <= 1'b0;
      first_ref_internal <= 1'b0;
      second_ref_internal <= 1'b0;
    end else if (ce) begin
      ctrl <= next_ctrl;
      res_first <= next_res_first;
      res_second <= next_res_second;
      reg_rdata <= next_rdata;
      side_done <= next_side_done;
      side_result <= next_side_result;
      side_sync <= {side_sync[0], side_start_pin};
      side_prev <= side_sync[1];
      first_start <= avg_launch[0];
      second_start <= avg_launch[1];
      first_conv_input_one <= next_ctrl.first_conv_input_one;
      first_ref_internal <= next_ctrl.ref_internal_first;
      second_ref_internal <= next_ctrl.ref_internal_second;
    end
  end

  // ********************************************************************
  // Checks
  // ********************************************************************
  property p_start_zero;
    @(posedge clk) disable iff (reset)
      !ctrl.start_first && !ctrl.start_second;
  endproperty
  a_start_zero: assert property (p_start_zero)
    else $error("start bit held in control register");

  property p_result_hold;
    @(posedge clk) disable iff (reset)
      !(ce && avg_valid[0]) |=> $stable(res_first);
  endproperty
  a_result_hold: assert property (p_result_hold)
    else $error("first result changed without a completion");

  property p_result_load;
    @(posedge clk) disable iff (reset)
      (ce && avg_valid[1]) |=> res_second == $past(avg_result[1]);
  endproperty
  a_result_load: assert property (p_result_load)
    else $error("second result not loaded whole");

  property p_read_split;
    @(posedge clk) disable iff (reset)
      (ce && reg_read && reg_addr == AAC_ADDR_FIRST_HI)
      |=> reg_rdata == $past(res_first[RESULT_W-1:AAC_HI_LSB]);
  endproperty
  a_read_split: assert property (p_read_split)
    else $error("upper result byte read wrong");

  property p_side_gate;
    @(posedge clk) disable iff (reset)
      (side_edge && !ctrl.side_port_enable && !ctrl_write) |-> avg_start == 2'h0;
  endproperty
  a_side_gate: assert property (p_side_gate)
    else $error("side port started while disabled");

  property p_side_owner;
    @(posedge clk) disable iff (reset)
      (side_edge && ctrl.side_port_enable && !ctrl_write && !ctrl.side_port_owner_select)
      |-> !go_second && go_first;
  endproperty
  a_side_owner: assert property (p_side_owner)
    else $error("side port drove the wrong converter");

  property p_ref_follow;
    @(posedge clk) disable iff (reset)
      ce |=> first_ref_internal == ctrl.ref_internal_first
        && second_ref_internal == ctrl.ref_internal_second;
  endproperty
  a_ref_follow: assert property (p_ref_follow)
    else $error("reference select out of step");

  property p_mux_follow;
    @(posedge clk) disable iff (reset)
      (ce && ctrl_write) |=> first_conv_input_one == $past(wr_fields.first_conv_input_one);
  endproperty
  a_mux_follow: assert property (p_mux_follow)
    else $error("input select did not follow write");

endmodule

// [sim/aac_conv_model.sv]
// Behavioural model of one housekeeping converter facing aac_control.
// Assumes one start pulse per sample and answers each with one done pulse.
module aac_conv_model import aac_pkg::*; #(
  parameter int DELAY = 3
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic start,
  input wire logic [AAC_RESULT_W-1:0] value,
  output aac_sample_t sample,
  output int n_starts
);
  timeunit 1ns;
  timeprecision 100ps;

  // ********************************************************************
  // Sample answer
  // ********************************************************************
  int wait_left;
  logic pending;

  // Data toggles outside the done cycle so a stale sample never looks valid
  always @(posedge clk) begin
    if (reset) begin
      pending <= 1'b0;
      wait_left <= 0;
      n_starts <= 0;
      sample <= '0;
    end else begin
      sample.done <= 1'b0;
      sample.data <= ~sample.data;
      if (start) begin
        pending <= 1'b1;
        wait_left <= DELAY;
        n_starts <= n_starts + 1;
      end else if (pending && wait_left <= 1) begin
        pending <= 1'b0;
        sample.done <= 1'b1;
        sample.data <= value;
      end else if (pending) begin
        wait_left <= wait_left - 1;
      end
    end
  end
endmodule

// [sim/aac_control_tb_top.sv]
// Self-checking bench for aac_control: register port, side port, averaging.
// Assumes two converter models answer the start pulses; ce stays high.
module aac_control_tb_top import aac_pkg::*; ();
  timeunit 1ns;
  timeprecision 100ps;

  // ********************************************************************
  // Signals and instances
  // ********************************************************************
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic ce = 1'b1;
  logic [7:0] reg_addr = 8'h00;
  logic reg_write = 1'b0;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_read = 1'b0;
  logic [7:0] reg_rdata;
  logic [AAC_COUNT_W-1:0] avg_count_code = 3'h0;
  logic side_start_pin = 1'b0;
  logic side_done;
  logic [AAC_RESULT_W-1:0] side_result;
  logic first_start;
  logic second_start;
  aac_sample_t first_sample;
  aac_sample_t second_sample;
  logic first_conv_input_one;
  logic first_ref_internal;
  logic second_ref_internal;
  logic [AAC_RESULT_W-1:0] first_value = 10'h2d5;
  logic [AAC_RESULT_W-1:0] second_value = 10'h13e;
  logic [7:0] rd;
  int first_starts;
  int second_starts;
  int n_side = 0;
  int n_errors = 0;
  int compares = 0;
  logic [7:0] cfg [4] = '{8'h36, 8'h04, 8'h22, 8'h00};
  logic [7:0] pins [4] = '{8'h07, 8'h02, 8'h05, 8'h00};

  aac_control uut (.clk(clk), .reset(reset), .ce(ce), .reg_addr(reg_addr),
    .reg_write(reg_write), .reg_wdata(reg_wdata), .reg_read(reg_read),
    .reg_rdata(reg_rdata), .avg_count_code(avg_count_code),
    .side_start_pin(side_start_pin), .side_done(side_done), .side_result(side_result),
    .first_start(first_start), .second_start(second_start),
    .first_sample(first_sample), .second_sample(second_sample),
    .first_conv_input_one(first_conv_input_one), .first_ref_internal(first_ref_internal),
    .second_ref_internal(second_ref_internal));
  aac_conv_model first_conv (.clk(clk), .reset(reset), .start(first_start),
    .value(first_value), .sample(first_sample), .n_starts(first_starts));
  aac_conv_model second_conv (.clk(clk), .reset(reset), .start(second_start),
    .value(second_value), .sample(second_sample), .n_starts(second_starts));

  always #5 clk = ~clk;

  // One-cycle pulse, so counting edges counts completions
  always @(posedge clk) begin
    if (side_done === 1'b1) n_side <= n_side + 1;
  end

  // ********************************************************************
  // Tasks
  // ********************************************************************
  task automatic stop_test();
    if (n_errors == 0 && compares > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic chk8(input logic [7:0] got, input logic [7:0] exp, input string msg);
    compares++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED at %0t: %s got %h exp %h", $time, msg, got, exp);
    end
  endtask

  task automatic chk10(input logic [9:0] got, input logic [9:0] exp, input string msg);
    compares++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED at %0t: %s got %h exp %h", $time, msg, got, exp);
    end
  endtask

  task automatic chk_n(input int got, input int exp, input string msg);
    compares++;
    if (got != exp) begin
      n_errors++;
      $display("CHECK FAILED at %0t: %s got %0d exp %0d", $time, msg, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    reg_addr = a;
    reg_wdata = d;
    reg_write = 1'b1;
    @(negedge clk);
    reg_write = 1'b0;
  endtask

  // Read data is taken a full cycle after the strobe; it holds until the next read
  task automatic rd_reg(input logic [7:0] a);
    @(negedge clk);
    reg_addr = a;
    reg_read = 1'b1;
    @(negedge clk);
    reg_read = 1'b0;
    @(negedge clk);
    rd = reg_rdata;
  endtask

  task automatic chk_res(input logic [7:0] a, input logic [9:0] e);
    rd_reg(a);
    chk8(rd, e[9:2], "result high");
    rd_reg(a + 8'h01);
    chk8(rd, {6'h00, e[1:0]}, "result low");
  endtask

  // Waits until no converter start or side completion has been seen for 30 cycles
  task automatic settle();
    int idle;
    int last;
    idle = 0;
    last = first_starts + second_starts + n_side;
    for (int i = 0; i < 3000 && idle < 30; i++) begin
      @(negedge clk);
      if (first_starts + second_starts + n_side == last) begin
        idle++;
      end else begin
        idle = 0;
        last = first_starts + second_starts + n_side;
      end
    end
  endtask

  // Writes control, optionally pulses the side pin, then checks counts
  task automatic run(input logic [7:0] ctrl, input logic [2:0] code, input logic side,
                     input int ef, input int es, input int ed);
    int f0;
    int s0;
    int d0;
    f0 = first_starts;
    s0 = second_starts;
    d0 = n_side;
    avg_count_code = code;
    wr(AAC_ADDR_CTRL, ctrl);
    if (side) begin
      side_start_pin = 1'b1;
      repeat (4) @(negedge clk);
      side_start_pin = 1'b0;
    end
    settle();
    rd_reg(AAC_ADDR_CTRL);
    chk8(rd, ctrl & 8'hf6, "control readback");
    chk_n(first_starts - f0, ef, "first sample count");
    chk_n(second_starts - s0, es, "second sample count");
    chk_n(n_side - d0, ed, "side completions");
  endtask

  // ********************************************************************
  // Tests
  // ********************************************************************
  initial begin
    repeat (3) @(negedge clk);
    reset = 1'b0;
    for (int a = 8'h1a; a <= 8'h22; a++) begin
      rd_reg(8'(a));
      chk8(rd, AAC_READ_ZERO, "reset value");
    end
    for (int i = 0; i < 4; i++) begin
      wr(AAC_ADDR_CTRL, cfg[i]);
      rd_reg(AAC_ADDR_CTRL);
      chk8(rd, cfg[i], "control readback");
      chk8({5'h00, first_conv_input_one, first_ref_internal, second_ref_internal},
           pins[i], "mux and reference");
    end
    run(8'h01, 3'h0, 1'b0, 1, 0, 0);
    chk_res(AAC_ADDR_FIRST_HI, first_value);
    wr(AAC_ADDR_FIRST_HI, 8'hff);
    wr(AAC_ADDR_FIRST_LO, 8'hff);
    chk_res(AAC_ADDR_FIRST_HI, first_value);
    run(8'h08, 3'h0, 1'b0, 0, 1, 0);
    chk_res(AAC_ADDR_SECOND_HI, second_value);
    chk_res(AAC_ADDR_FIRST_HI, first_value);
    // Count codes 0 to 6, each with a fresh value so a stale result shows
    for (int k = 0; k < 7; k++) begin
      first_value = 10'h3a0 + 10'(k);
      run(8'h01, 3'(k), 1'b0, 1 << k, 0, 0);
      chk_res(AAC_ADDR_FIRST_HI, first_value);
    end
    first_value = 10'h055;
    run(8'h01, AAC_CODE_RESERVED, 1'b0, 0, 0, 0);
    chk_res(AAC_ADDR_FIRST_HI, 10'h3a6);
    first_value = 10'h0f3;
    run(8'h80, 3'h0, 1'b1, 1, 0, 1);
    chk10(side_result, first_value, "side result first");
    second_value = 10'h2aa;
    run(8'hc0, 3'h0, 1'b1, 0, 1, 1);
    chk10(side_result, second_value, "side result second");
    chk_res(AAC_ADDR_SECOND_HI, second_value);
    run(8'h40, 3'h0, 1'b1, 0, 0, 0);
    stop_test();
  end

  // Watchdog: the tests need well under 10000 cycles
  initial begin
    #200000;
    n_errors++;
    $display("CHECK FAILED at %0t: watchdog expired", $time);
    stop_test();
  end
endmodule
